// [design/prog_mem.sv]
// program memory with registered read data
`timescale 1ns/1ps
`include "sleep_cfg.svh"
module prog_mem (
  input wire logic clock,
  pmem_link_if.mem link
);
  logic [`SWC_PM_DW-1:0] mem [0:(1 << `SWC_PM_AW)-1];

  // programming write port
  always_ff @(posedge clock) begin
    if (link.wr_en) begin
      mem[link.wr_addr] <= link.wr_data;
    end
  end

  // read data comes out of a register
  always_ff @(posedge clock) begin
    if (link.rd_en) begin
      link.rd_data <= mem[link.rd_addr];
    end
  end
endmodule

// [design/sleep_wakeup_control.sv]
// sleep entry, wake-up, debugger reservation and readback control
// Operation
// - a sleep_op from the decoder enters power-down
// - sleep entry clears watchdog, clears power_down_flag, sets timeout_flag, stops oscillator
// - port drive levels and enables are frozen while asleep
// - wake on master clear, enabled watchdog time-out, or enabled interrupt
// - master clear in sleep resets fully; other wakes resume without reset
// - power_down_flag set at power-up, cleared by an executed sleep_op unless a time-out lands in the same cycle
// - timeout_flag cleared when a watchdog time-out wakes the device
// - only the wake-capable peripheral interrupts may wake the device
// - clock-dependent peripherals raise no interrupt while asleep
// - while sleep_op executes the next instruction is prefetched
// - wake needs the source enable bit, regardless of global_irq_enable
// - after interrupt wake run next instruction, vector to 0004h if enabled
// - a pending enabled interrupt turns sleep_op into a no-op
// - interrupt during or after sleep_op completes sleep then wakes at once
// - crystal and low-power modes wait 1024 oscillator periods; RC skips it
// - debugger fuse at zero enables debugger and reserves its resources
// - debugger owns two pins, one stack level, top 100h words, some RAM
// - program memory readback allowed only with code protection off
// - watchdog time-out resets when awake, wakes and continues when asleep
// - taking an interrupt clears global_irq_enable, pushes, loads 0004h
`timescale 1ns/1ps
`include "sleep_cfg.svh"
module sleep_wakeup_control #(
  parameter int unsigned WDT_BASE_CYCLES = `SWC_WDT_BASE
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic master_clear_pin_n,
  input wire logic sleep_op,
  input wire logic watchdog_clear_op,
  input wire logic return_irq_op,
  input wire logic wdt_enable,
  input wire logic [2:0] wdt_postscale,
  input wire logic [1:0] osc_mode,
  input wire logic gie_wr_en,
  input wire logic gie_wr_val,
  input wire logic [`SWC_IRQ_N-1:0] irq_flags,
  input wire logic [`SWC_IRQ_N-1:0] irq_enables,
  input wire logic [`SWC_PORT_W-1:0] port_drive_in,
  input wire logic [`SWC_PORT_W-1:0] port_oe_in,
  input wire logic debug_fuse,
  input wire logic [1:0] code_protect,
  input wire logic [`SWC_PM_AW-1:0] user_prog_addr,
  input wire logic [8:0] user_data_addr,
  input wire logic verify_req,
  input wire logic [`SWC_PM_AW-1:0] verify_addr,
  input wire logic prog_wr_en,
  input wire logic [`SWC_PM_AW-1:0] prog_wr_addr,
  input wire logic [`SWC_PM_DW-1:0] prog_wr_data,
  output logic [7:0] status_q,
  output logic global_irq_enable,
  output logic osc_drive_en_q,
  output logic core_run_q,
  output logic device_reset_q,
  output logic prefetch_q,
  output logic resume_q,
  output logic dummy_cycle_q,
  output logic vector_load_q,
  output logic stack_push_q,
  output logic [`SWC_PC_W-1:0] pc_load_q,
  output logic [`SWC_PORT_W-1:0] port_drive_q,
  output logic [`SWC_PORT_W-1:0] port_oe_q,
  output logic debug_active_q,
  output logic [3:0] stack_levels_q,
  output logic debug_region_hit_q,
  output logic verify_valid_q,
  output logic verify_refused_q,
  output logic [`SWC_PM_DW-1:0] verify_data_q
);
  // start-up wait counted in core clock cycles
  localparam int unsigned OST_CYCLES = `SWC_OST_CYCLES;

  // power state, pin synchroniser and start-up counter
  sleep_pkg::pwr_state_t state_q;
  logic master_clear_pin_meta_q;
  logic master_clear_pin_sync_q;
  logic [10:0] ost_cnt_q;
  // wake and interrupt decode
  logic pending_any;
  logic pending_wake;
  logic sleep_go;
  logic sleep_nop;
  logic wdt_wake;
  logic irq_wake;
  logic take_irq;
  logic crystal_mode;
  logic verify_pend_q;

  // carriers toward the watchdog and the program memory
  wdt_link_if wdt_link ();
  pmem_link_if pmem_link ();

  // master clear pin passes two flops before use
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      master_clear_pin_meta_q <= 1'b0;
      master_clear_pin_sync_q <= 1'b0;
    end else begin
      master_clear_pin_meta_q <= master_clear_pin_n;
      master_clear_pin_sync_q <= master_clear_pin_meta_q;
    end
  end

  // wake sources: enable bit required, global enable ignored
  // a pending enabled flag turns sleep_op into a no-op, so the watchdog keeps its count
  assign pending_any = |(irq_flags & irq_enables);
  assign pending_wake = |(irq_flags & irq_enables & `SWC_WAKE_MASK);
  assign sleep_go = sleep_op && state_q == sleep_pkg::st_run && !pending_any;
  assign sleep_nop = sleep_op && state_q == sleep_pkg::st_run && pending_any;
  assign wdt_wake = state_q == sleep_pkg::st_sleep && wdt_enable && wdt_link.timeout;
  assign irq_wake = state_q == sleep_pkg::st_sleep && pending_wake;
  assign take_irq = state_q == sleep_pkg::st_run && global_irq_enable && pending_any && !sleep_op;
  assign crystal_mode = osc_mode != sleep_pkg::osc_rc;

  // watchdog clear on clear op, on executed sleep and while master clear is low
  assign wdt_link.clear = watchdog_clear_op || sleep_go || !master_clear_pin_sync_q;
  assign wdt_link.enable = wdt_enable;
  assign wdt_link.postscale = wdt_postscale;

  wdt_unit #(
    .BASE_CYCLES(WDT_BASE_CYCLES)
  ) u_wdt (
    .clock(clock),
    .rstn(rstn),
    .link(wdt_link.dog)
  );

  // power state sequencing
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= sleep_pkg::st_run;
      ost_cnt_q <= 11'h0;
    end else if (!master_clear_pin_sync_q) begin
      state_q <= sleep_pkg::st_run;
      ost_cnt_q <= 11'h0;
    end else begin
      case (state_q)
        sleep_pkg::st_run: begin
          if (sleep_go) begin
            state_q <= sleep_pkg::st_sleep;
          end
        end
        sleep_pkg::st_sleep: begin
          if (wdt_wake || irq_wake) begin
            ost_cnt_q <= 11'h0;
            state_q <= crystal_mode ? sleep_pkg::st_ost : sleep_pkg::st_resume;
          end
        end
        sleep_pkg::st_ost: begin
          if (ost_cnt_q == 11'(OST_CYCLES - 1)) begin
            state_q <= sleep_pkg::st_resume;
          end else begin
            ost_cnt_q <= ost_cnt_q + 11'h1;
          end
        end
        sleep_pkg::st_resume: begin
          state_q <= (global_irq_enable && pending_any) ? sleep_pkg::st_dummy1 : sleep_pkg::st_run;
        end
        sleep_pkg::st_dummy1: begin
          state_q <= sleep_pkg::st_dummy2;
        end
        sleep_pkg::st_dummy2: begin
          state_q <= sleep_pkg::st_run;
        end
        default: begin
          state_q <= sleep_pkg::st_run;
        end
      endcase
    end
  end

  // status flags: power-up sets both
  // a time-out in the same cycle as a sleep or clear op leaves timeout_flag low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_q <= `SWC_STATUS_RST;
    end else if (wdt_enable && wdt_link.timeout) begin
      status_q[`SWC_TO_BIT] <= 1'b0;
    end else if (sleep_go) begin
      status_q[`SWC_PD_BIT] <= 1'b0;
      status_q[`SWC_TO_BIT] <= 1'b1;
    end else if (watchdog_clear_op) begin
      status_q[`SWC_PD_BIT] <= 1'b1;
      status_q[`SWC_TO_BIT] <= 1'b1;
    end
  end

  // global interrupt enable: vector clears, return sets
  // the vector clear wins over a return or software write in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      global_irq_enable <= 1'b0;
    end else if (!master_clear_pin_sync_q) begin
      global_irq_enable <= 1'b0;
    end else if (take_irq || state_q == sleep_pkg::st_dummy2) begin
      global_irq_enable <= 1'b0;
    end else if (return_irq_op) begin
      global_irq_enable <= 1'b1;
    end else if (gie_wr_en) begin
      global_irq_enable <= gie_wr_val;
    end
  end

  // oscillator driver and core clock gating
  // the oscillator comes back one cycle after the wake edge, together with resume_q in RC mode
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      osc_drive_en_q <= 1'b1;
      core_run_q <= 1'b1;
    end else begin
      osc_drive_en_q <= !sleep_go && (osc_drive_en_q || state_q != sleep_pkg::st_sleep || !master_clear_pin_sync_q);
      core_run_q <= state_q == sleep_pkg::st_run && !sleep_go;
    end
  end

  // device reset from master clear or an awake watchdog time-out
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      device_reset_q <= 1'b1;
    end else begin
      device_reset_q <= !master_clear_pin_sync_q ||
        (wdt_enable && wdt_link.timeout && state_q != sleep_pkg::st_sleep);
    end
  end

  // instruction flow pulses toward the decoder
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prefetch_q <= 1'b0;
      resume_q <= 1'b0;
      dummy_cycle_q <= 1'b0;
      vector_load_q <= 1'b0;
      stack_push_q <= 1'b0;
      pc_load_q <= `SWC_PC_W'(0);
    end else begin
      prefetch_q <= sleep_op && state_q == sleep_pkg::st_run;
      resume_q <= state_q == sleep_pkg::st_resume;
      dummy_cycle_q <= state_q == sleep_pkg::st_dummy1 || state_q == sleep_pkg::st_dummy2;
      vector_load_q <= take_irq || state_q == sleep_pkg::st_dummy2;
      stack_push_q <= take_irq || state_q == sleep_pkg::st_dummy2;
      pc_load_q <= `SWC_VECTOR;
    end
  end

  // port drive frozen while the core is stopped
  // the pins keep the last run-time value through sleep and start-up
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      port_drive_q <= `SWC_PORT_W'(0);
      port_oe_q <= `SWC_PORT_W'(0);
    end else if (state_q == sleep_pkg::st_run && !sleep_go) begin
      port_drive_q <= port_drive_in;
      port_oe_q <= port_oe_in;
    end
  end

  // debugger resources claimed when the fuse reads zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      debug_active_q <= 1'b0;
      stack_levels_q <= `SWC_STACK_FULL;
      debug_region_hit_q <= 1'b0;
    end else begin
      debug_active_q <= !debug_fuse;
      stack_levels_q <= debug_fuse ? `SWC_STACK_FULL : `SWC_STACK_DBG;
      debug_region_hit_q <= !debug_fuse && (user_prog_addr >= `SWC_DBG_PM_BASE ||
        user_data_addr[6:0] == `SWC_DBG_RAM_LO ||
        (user_data_addr >= `SWC_DBG_RAM_HI0 && user_data_addr <= `SWC_DBG_RAM_HI1));
    end
  end

  // program memory readback gated by code protection
  assign pmem_link.rd_en = verify_req && code_protect == `SWC_CP_OFF;
  assign pmem_link.rd_addr = verify_addr;
  assign pmem_link.wr_en = prog_wr_en;
  assign pmem_link.wr_addr = prog_wr_addr;
  assign pmem_link.wr_data = prog_wr_data;

  prog_mem u_pmem (
    .clock(clock),
    .link(pmem_link.mem)
  );

  // readback data two cycles after the request, refusal one cycle after
  // the memory adds one register stage, the answer flop the second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      verify_pend_q <= 1'b0;
      verify_valid_q <= 1'b0;
      verify_refused_q <= 1'b0;
      verify_data_q <= `SWC_PM_DW'(0);
    end else begin
      verify_pend_q <= pmem_link.rd_en;
      verify_valid_q <= verify_pend_q;
      verify_refused_q <= verify_req && code_protect != `SWC_CP_OFF;
      if (verify_pend_q) begin
        verify_data_q <= pmem_link.rd_data;
      end
    end
  end
endmodule

// [design/wdt_unit.sv]
// watchdog counter with postscaler, runs in sleep too
`timescale 1ns/1ps
`include "sleep_cfg.svh"
module wdt_unit #(
  parameter int unsigned BASE_CYCLES = `SWC_WDT_BASE
) (
  input wire logic clock,
  input wire logic rstn,
  wdt_link_if.dog link
);
  logic [31:0] cnt_q;
  logic [31:0] limit;

  // time-out length grows by the postscaler power of two
  assign limit = BASE_CYCLES << link.postscale;

  // counter cleared by clear ops, emits one-cycle time-out pulse
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 32'h0;
      link.timeout <= 1'b0;
    end else begin
      link.timeout <= 1'b0;
      if (link.clear || !link.enable) begin
        cnt_q <= 32'h0;
      end else if (cnt_q + 32'h1 >= limit) begin
        cnt_q <= 32'h0;
        link.timeout <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end
endmodule

// [pkg/core_if.sv]
// carriers between the controller, its watchdog and its program memory
`timescale 1ns/1ps
`include "sleep_cfg.svh"
interface wdt_link_if;
  logic clear;
  logic enable;
  logic [2:0] postscale;
  logic timeout;
  modport ctrl (output clear, output enable, output postscale, input timeout);
  modport dog (input clear, input enable, input postscale, output timeout);
endinterface

interface pmem_link_if;
  logic rd_en;
  logic [`SWC_PM_AW-1:0] rd_addr;
  logic [`SWC_PM_DW-1:0] rd_data;
  logic wr_en;
  logic [`SWC_PM_AW-1:0] wr_addr;
  logic [`SWC_PM_DW-1:0] wr_data;
  modport ctrl (output rd_en, output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
  modport mem (input rd_en, input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface

// [pkg/sleep_cfg.svh]
// constants for the sleep and wake-up controller
`ifndef SLEEP_CFG_SVH
`define SLEEP_CFG_SVH
`define SWC_CLK_NS 10
`define SWC_TOSC_NS 10
`define SWC_OST_TOSC 1024
`define SWC_OST_CYCLES ((`SWC_OST_TOSC * `SWC_TOSC_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS)
`define SWC_PD_BIT 3
`define SWC_TO_BIT 4
`define SWC_STATUS_RST 8'h18
`define SWC_IRQ_N 10
`define SWC_WAKE_MASK 10'h3ff
`define SWC_PORT_W 22
`define SWC_VECTOR 13'h0004
`define SWC_PC_W 13
`define SWC_PM_AW 11
`define SWC_PM_DW 14
`define SWC_DBG_PM_BASE 11'h700
`define SWC_DBG_RAM_LO 7'h70
`define SWC_DBG_RAM_HI0 9'h1eb
`define SWC_DBG_RAM_HI1 9'h1ef
`define SWC_STACK_FULL 4'h8
`define SWC_STACK_DBG 4'h7
`define SWC_CP_OFF 2'h3
`define SWC_WDT_BASE 18000
`endif

// [pkg/sleep_pkg.sv]
// types shared by the sleep and wake-up controller
package sleep_pkg;
  typedef enum logic [2:0] {
    st_run, st_sleep, st_ost, st_resume, st_dummy1, st_dummy2
  } pwr_state_t;
  typedef enum logic [1:0] {
    osc_lp, osc_xt, osc_hs, osc_rc
  } osc_mode_t;
endpackage

// [sim/periph_model.sv]
// interrupt sources and external reset pin around the controller
`timescale 1ns/1ps
module periph_model (
  input wire logic clock,
  input wire logic [9:0] raise,
  input wire logic drop,
  input wire logic slow,
  input wire logic hold_reset,
  output logic [9:0] irq_flags,
  output logic master_clear_pin_n
);
  logic [9:0] lag_q;
  // only wake-capable sources raise; a slow source flags a cycle later
  always_ff @(posedge clock) begin
    lag_q <= raise;
    irq_flags <= drop ? 10'h000 : irq_flags | (slow ? lag_q : raise);
  end
  // pulled-up pin, low only on request
  assign master_clear_pin_n = !hold_reset;
endmodule

// [sim/swc_assertions.sv]
// concurrent checks on the sleep and wake-up controller ports
`timescale 1ns/1ps
`include "sleep_cfg.svh"
module swc_assertions #(
  parameter int unsigned WDT_BASE_CYCLES = `SWC_WDT_BASE
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic master_clear_pin_n,
  input wire logic sleep_op,
  input wire logic [1:0] osc_mode,
  input wire logic [`SWC_IRQ_N-1:0] irq_flags,
  input wire logic [`SWC_IRQ_N-1:0] irq_enables,
  input wire logic debug_fuse,
  input wire logic [7:0] status_q,
  input wire logic global_irq_enable,
  input wire logic osc_drive_en_q,
  input wire logic core_run_q,
  input wire logic device_reset_q,
  input wire logic resume_q,
  input wire logic dummy_cycle_q,
  input wire logic vector_load_q,
  input wire logic stack_push_q,
  input wire logic [`SWC_PC_W-1:0] pc_load_q,
  input wire logic [`SWC_PORT_W-1:0] port_drive_q,
  input wire logic [`SWC_PORT_W-1:0] port_oe_q,
  input wire logic debug_active_q,
  input wire logic [3:0] stack_levels_q
);
  localparam int OST_LO = `SWC_OST_CYCLES;
  localparam int OST_HI = `SWC_OST_CYCLES + 4;
  logic pend;
  logic asleep;
  // an enabled flag is pending; the core is parked with its oscillator off
  assign pend = |(irq_flags & irq_enables);
  assign asleep = !core_run_q && !osc_drive_en_q && master_clear_pin_n;
  logic [11:0] ost_seen_q;
  // cycles with the oscillator back on and the core still held, cleared at resume
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ost_seen_q <= 12'h0;
    end else if (core_run_q || resume_q) begin
      ost_seen_q <= 12'h0;
    end else if (osc_drive_en_q) begin
      ost_seen_q <= ost_seen_q + 12'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_sleep_entry: assert property (
    core_run_q && sleep_op && !pend && !device_reset_q |=> !core_run_q && !osc_drive_en_q && status_q == 8'h10
  ) else $error("sleep entry outputs wrong");
  chk_sleep_noop: assert property (
    core_run_q && sleep_op && pend && !device_reset_q |=> core_run_q && $stable(status_q)
  ) else $error("pending sleep not a no-op");
  chk_ports_frozen: assert property (
    !core_run_q |-> $stable(port_drive_q) && $stable(port_oe_q)
  ) else $error("ports moved while parked");
  chk_master_clear_pin_reset: assert property (
    !master_clear_pin_n |-> ##3 device_reset_q
  ) else $error("master clear not seen");
  chk_vector_load: assert property (
    vector_load_q |-> stack_push_q && !global_irq_enable && pc_load_q == `SWC_VECTOR
  ) else $error("vector entry wrong");
  chk_dummy_pair: assert property (
    $rose(dummy_cycle_q) |=> (dummy_cycle_q && vector_load_q) ##1 !dummy_cycle_q
  ) else $error("dummy cycles wrong");
  chk_wake_rc: assert property (
    asleep && pend && osc_mode == 2'h3 |-> ##[1:3] resume_q
  ) else $error("rc wake late");
  chk_wake_ost: assert property (
    ost_seen_q <= 12'(OST_HI) && (!resume_q || osc_mode == 2'h3 || ost_seen_q >= 12'(OST_LO))
  ) else $error("start-up delay wrong");
  chk_debug_claim: assert property (
    !debug_fuse ##1 !debug_fuse |-> debug_active_q && stack_levels_q == `SWC_STACK_DBG
  ) else $error("debugger claim wrong");
endmodule
bind sleep_wakeup_control swc_assertions #(.WDT_BASE_CYCLES(WDT_BASE_CYCLES)) swc_assertions_inst (.*);

// [sim/tb.sv]
// self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ps
module tb;
  logic clock, rstn, sleep_op, watchdog_clear_op, return_irq_op, wdt_enable, gie_wr_en, gie_wr_val;
  logic debug_fuse, verify_req, prog_wr_en, drop, hold_reset, slow, master_clear_pin_n;
  logic global_irq_enable, osc_drive_en_q, core_run_q, device_reset_q, prefetch_q, resume_q;
  logic dummy_cycle_q, vector_load_q, stack_push_q, debug_active_q, debug_region_hit_q;
  logic verify_valid_q, verify_refused_q;
  logic [2:0] wdt_postscale;
  logic [1:0] osc_mode, code_protect;
  logic [9:0] irq_enables, irq_flags, raise;
  logic [21:0] port_drive_in, port_oe_in, port_drive_q, port_oe_q;
  logic [10:0] user_prog_addr, verify_addr, prog_wr_addr;
  logic [8:0] user_data_addr;
  logic [13:0] prog_wr_data, verify_data_q;
  logic [7:0] status_q;
  logic [12:0] pc_load_q;
  logic [3:0] stack_levels_q;
  logic [8:0] da [7] = '{9'h070, 9'h0f0, 9'h170, 9'h1f0, 9'h1eb, 9'h1ef, 9'h1ea};
  int fail_count, n_tests, n_vec, n_dum, cyc, v;
  sleep_wakeup_control #(.WDT_BASE_CYCLES(16)) sleep_wakeup_control_inst (.*);
  periph_model periph_model_inst (.*);
  // clock and event counters
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (vector_load_q === 1'b1) n_vec++;
    if (dummy_cycle_q === 1'b1) n_dum++;
  end
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait: 0 resume, 1 device reset, 2 vector load
  task hold(input int sel);
    cyc = 0;
    while (cyc < 3000 && (sel == 0 ? resume_q : sel == 1 ? device_reset_q : vector_load_q) !== 1'b1) begin
      step(1);
      cyc++;
    end
    if (cyc == 3000) begin
      fail_count++;
      $display("Error %0t: wait ran out", $time);
      complete_run();
    end
  endtask
  task sleep_now;
    sleep_op = 1;
    step(1);
    sleep_op = 0;
    chk(prefetch_q, 1);
  endtask
  task clear_flags;
    drop = 1;
    step(1);
    drop = 0;
  endtask
  task t_rc_wake;
    osc_mode = 2'h3;
    irq_enables = 10'h001;
    port_drive_in = 22'h2aaaaa;
    port_oe_in = 22'h0f0f0f;
    step(2);
    sleep_now();
    chk(status_q, 8'h10);
    chk({core_run_q, osc_drive_en_q}, 0);
    port_drive_in = 22'h155555;
    port_oe_in = 22'h30f0f0;
    raise = 10'h002;
    step(3);
    chk(core_run_q, 0);
    chk(port_drive_q, 22'h2aaaaa);
    chk(port_oe_q, 22'h0f0f0f);
    v = n_vec;
    raise = 10'h001;
    hold(0);
    raise = 0;
    chk(cyc < 6, 1);
    step(3);
    chk({n_vec == v, core_run_q}, 2'b11);
    clear_flags();
    $display("rc wake done");
  endtask
  task t_xt_vec;
    osc_mode = 2'h1;
    slow = 1;
    gie_wr_en = 1;
    gie_wr_val = 1;
    step(1);
    gie_wr_en = 0;
    v = n_dum;
    raise = 10'h001;
    sleep_now();
    raise = 0;
    step(1);
    chk(status_q, 8'h10);
    hold(0);
    chk(cyc > 1022 && cyc < 1031, 1);
    hold(2);
    chk({dummy_cycle_q, stack_push_q, global_irq_enable, pc_load_q}, {3'b110, 13'h0004});
    step(1);
    chk(n_dum - v, 2);
    clear_flags();
    return_irq_op = 1;
    step(1);
    return_irq_op = 0;
    slow = 0;
    raise = 10'h001;
    hold(2);
    raise = 0;
    chk({stack_push_q, global_irq_enable}, 2'b10);
    clear_flags();
    $display("vectored wake done");
  endtask
  task t_noop;
    watchdog_clear_op = 1;
    step(1);
    watchdog_clear_op = 0;
    raise = 10'h001;
    step(2);
    raise = 0;
    sleep_now();
    step(1);
    chk({core_run_q, status_q}, 9'h118);
    clear_flags();
    $display("no-op sleep done");
  endtask
  task t_wdt;
    osc_mode = 2'h3;
    wdt_enable = 1;
    watchdog_clear_op = 1;
    step(1);
    watchdog_clear_op = 0;
    sleep_now();
    hold(0);
    chk({device_reset_q, status_q}, 9'h000);
    hold(1);
    wdt_enable = 0;
    chk(cyc < 40, 1);
    step(4);
    $display("watchdog done");
  endtask
  task t_master_clear_pin;
    sleep_now();
    hold_reset = 1;
    step(4);
    chk(device_reset_q, 1);
    hold_reset = 0;
    step(4);
    chk({device_reset_q, core_run_q, osc_drive_en_q}, 3'b011);
    $display("master clear done");
  endtask
  task t_debug;
    debug_fuse = 0;
    for (int i = 0; i < 7; i++) begin
      user_data_addr = da[i];
      step(2);
      chk({debug_active_q, stack_levels_q, debug_region_hit_q}, {5'h17, i < 6});
    end
    user_prog_addr = 11'h700;
    step(2);
    chk(debug_region_hit_q, 1);
    debug_fuse = 1;
    step(2);
    chk({debug_active_q, stack_levels_q}, 5'h08);
    $display("debugger done");
  endtask
  task t_verify;
    prog_wr_en = 1;
    prog_wr_addr = 11'h123;
    prog_wr_data = 14'h2a5c;
    step(1);
    prog_wr_en = 0;
    code_protect = 2'h3;
    verify_req = 1;
    verify_addr = 11'h123;
    step(1);
    verify_req = 0;
    step(1);
    chk({verify_valid_q, verify_data_q}, 15'h6a5c);
    code_protect = 2'h0;
    verify_req = 1;
    step(1);
    verify_req = 0;
    chk(verify_refused_q, 1);
    step(1);
    chk(verify_valid_q, 0);
    $display("readback done");
  endtask
  // reset, then each scenario in turn
  initial begin
    {rstn, sleep_op, watchdog_clear_op, return_irq_op, wdt_enable, gie_wr_en, gie_wr_val} = 0;
    {verify_req, prog_wr_en, hold_reset, slow, wdt_postscale, osc_mode, code_protect} = 0;
    {irq_enables, raise, port_drive_in, port_oe_in, verify_addr, prog_wr_addr} = 0;
    {user_data_addr, prog_wr_data} = 0;
    user_prog_addr = 11'h010;
    debug_fuse = 1;
    drop = 1;
    step(10);
    rstn = 1;
    drop = 0;
    step(4);
    t_rc_wake();
    t_xt_vec();
    t_noop();
    t_wdt();
    t_master_clear_pin();
    t_debug();
    t_verify();
    complete_run();
  end
endmodule
